// [rtl/adc_ctl_pkg.sv]
// Constants shared by the converter control core and its serial front end.
// Assumes a single 40 MHz system clock and a synchronous active-low reset.
package adc_ctl_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned CAL_CYCLES    = 80_000;
    localparam int unsigned CYC_SHORT     = 24;
    localparam int unsigned CYC_LONG      = 32;
    localparam int unsigned CTRL_BITS     = 8;
    localparam logic [4:0]  CONV_SHORT    = 5'(CYC_SHORT - CTRL_BITS);
    localparam logic [4:0]  CONV_LONG     = 5'(CYC_LONG - CTRL_BITS);
    localparam logic [7:0]  DIV_RESET     = 8'h09;

    // ------------------------------------------------------------------
    // Control byte layout
    // ------------------------------------------------------------------
    localparam int unsigned CB_POL        = 6;
    localparam int unsigned CB_CLK_INT    = 5;
    localparam int unsigned CB_MODE_HI    = 4;
    localparam int unsigned CB_MODE_LO    = 3;
    localparam int unsigned CB_GPO_MSB    = 2;
    localparam logic [1:0]  MODE_SHORT    = 2'h0;
    localparam logic [1:0]  MODE_CAL      = 2'h1;
    localparam logic [1:0]  MODE_POWER_DOWN_PIN_N     = 2'h2;
    localparam logic [1:0]  MODE_LONG     = 2'h3;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [3:0]  REG_STATUS    = 4'h0;
    localparam logic [3:0]  REG_RESULT    = 4'h4;
    localparam logic [3:0]  REG_CONFIG    = 4'h8;
    localparam int unsigned ST_PDN        = 0;
    localparam int unsigned ST_CONVERTING = 1;
    localparam int unsigned ST_CALIB      = 2;
    localparam int unsigned ST_BIPOLAR    = 3;
    localparam int unsigned ST_ACQ_LONG   = 4;
    localparam int unsigned ST_PIN_PDN    = 5;
    localparam int unsigned ST_CAL_DONE   = 6;

endpackage

// [rtl/ser_if.sv]
// Carries serial port events from the front end to the control core.
// Assumes both ends sit on the same system clock.
`timescale 1ns/10ps
interface ser_if;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       start_pulse;
    logic       pol_pulse;
    logic       pol_bit;
    logic       byte_pulse;
    logic [7:0] byte_data;
    logic       hold;

    modport rx (output sclk_rise, sclk_fall, start_pulse, pol_pulse,
                output pol_bit, byte_pulse, byte_data, input hold);
    modport core (input sclk_rise, sclk_fall, start_pulse, pol_pulse,
                  input pol_bit, byte_pulse, byte_data, output hold);
endinterface

// [rtl/ser_rx.sv]
// Serial front end: sclk edge detection, start bit hunt, control byte.
// Assumes sclk, din and cs_n are already synchronous to the system clock.
`timescale 1ns/10ps
module ser_rx
    import adc_ctl_pkg::*;
(
    input  wire logic i_clk_sys,
    input  wire logic i_rstn,
    input  wire logic i_sclk,
    input  wire logic i_din,
    input  wire logic i_cs_n,
    ser_if.rx         bus
);
    logic       sclk_reg,  sclk_next;
    logic [2:0] cnt_reg,   cnt_next;
    logic [7:0] sh_reg,    sh_next;
    logic       start_reg, start_next;
    logic       pol_reg,   pol_next;
    logic       polb_reg,  polb_next;
    logic       byte_reg,  byte_next;
    logic       rise;

    assign rise = i_sclk & ~sclk_reg;

    always_comb begin
        sclk_next  = i_sclk;
        cnt_next   = cnt_reg;
        sh_next    = sh_reg;
        start_next = 1'b0;
        pol_next   = 1'b0;
        polb_next  = polb_reg;
        byte_next  = 1'b0;
        if (i_cs_n) begin
            cnt_next = 3'h0;
        end else if (rise && cnt_reg == 3'h0) begin
            // While the core owns sclk for a conversion, no start is hunted.
            if (i_din && !bus.hold) begin
                start_next = 1'b1;
                cnt_next   = 3'h1;
                sh_next    = 8'h01;
            end
        end else if (rise) begin
            sh_next  = {sh_reg[6:0], i_din};
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == 3'h1) begin
                pol_next  = 1'b1;
                polb_next = i_din;
            end
            if (cnt_reg == 3'h7) begin
                byte_next = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            sclk_reg  <= 1'b0;
            cnt_reg   <= 3'h0;
            sh_reg    <= 8'h00;
            start_reg <= 1'b0;
            pol_reg   <= 1'b0;
            polb_reg  <= 1'b0;
            byte_reg  <= 1'b0;
        end else begin
            sclk_reg  <= sclk_next;
            cnt_reg   <= cnt_next;
            sh_reg    <= sh_next;
            start_reg <= start_next;
            pol_reg   <= pol_next;
            polb_reg  <= polb_next;
            byte_reg  <= byte_next;
        end
    end

    assign bus.sclk_rise   = rise;
    assign bus.sclk_fall   = ~i_sclk & sclk_reg;
    assign bus.start_pulse = start_reg;
    assign bus.pol_pulse   = pol_reg;
    assign bus.pol_bit     = polb_reg;
    assign bus.byte_pulse  = byte_reg;
    assign bus.byte_data   = sh_reg;
endmodule

// [rtl/adc_shutdown_ctl.sv]
// Converter control core: mode decode, conversion timing, calibration,
// software and pin power-down, result coding and an Avalon-MM slave.
// Assumes serial pins are synchronous to i_clk_sys and that the analog
// core presents an offset-binary code on i_raw_code at conversion end.
`timescale 1ns/10ps

module adc_shutdown_ctl
    import adc_ctl_pkg::*;
#(
    parameter int unsigned CAL_LEN = CAL_CYCLES
)(
    input  wire logic        i_clk_sys,
    input  wire logic        i_rstn,
    input  wire logic        i_sclk,
    input  wire logic        i_din,
    input  wire logic        i_cs_n,
    input  wire logic        i_power_down_pin_n,
    input  wire logic [13:0] i_raw_code,
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    output logic             o_dout,
    output logic      [2:0]  o_gpo,
    output logic             o_busy,
    output logic             o_powered_down,
    output logic             o_input_polarity_select
);
    // ------------------------------------------------------------------
    // Serial front end
    // ------------------------------------------------------------------
    ser_if sif ();

    ser_rx u_rx (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_sclk    (i_sclk),
        .i_din     (i_din),
        .i_cs_n    (i_cs_n),
        .bus       (sif)
    );

    // ------------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE, S_CONV, S_CAL, S_SW_PDN, S_PIN_PDN
    } state_t;

    state_t      state_reg,   state_next;
    logic [4:0]  conv_reg,    conv_next;
    logic [16:0] cal_reg,     cal_next;
    logic [7:0]  div_reg,     div_next;
    logic        clk_int_reg, clk_int_next;
    logic        long_reg,    long_next;
    logic        pol_reg,     pol_next;
    logic        pend_reg,    pend_next;
    logic        caldone_reg, caldone_next;
    logic [2:0]  gpo_reg,     gpo_next;
    logic [13:0] result_reg,  result_next;
    logic [13:0] sh_reg,      sh_next;
    logic [7:0]  cfg_reg,     cfg_next;
    logic        ack_reg,     ack_next;
    logic [31:0] rdata_reg,   rdata_next;
    logic [1:0]  mode;
    logic        tick;
    logic        req;

    assign mode = {sif.byte_data[CB_MODE_HI], sif.byte_data[CB_MODE_LO]};
    assign tick = clk_int_reg ? (div_reg == 8'h00) : sif.sclk_rise;
    assign req  = i_avs_read | i_avs_write;

    // The external clock belongs to an externally clocked conversion until it ends.
    assign sif.hold = (state_reg == S_CONV) && !clk_int_reg;

    always_comb begin
        state_next   = state_reg;
        conv_next    = conv_reg;
        cal_next     = cal_reg;
        div_next     = (div_reg == 8'h00) ? cfg_reg : div_reg - 8'h01;
        clk_int_next = clk_int_reg;
        long_next    = long_reg;
        pol_next     = pol_reg;
        pend_next    = pend_reg;
        caldone_next = caldone_reg;
        gpo_next     = gpo_reg;
        result_next  = result_reg;
        sh_next      = sh_reg;
        if (sif.sclk_fall && !i_cs_n) begin
            sh_next = {sh_reg[12:0], 1'b0};
        end
        if (!i_power_down_pin_n) begin
            state_next = S_PIN_PDN;
        end else begin
            case (state_reg)
                S_PIN_PDN: begin
                    state_next = S_IDLE;
                end
                S_SW_PDN: begin
                    if (sif.start_pulse) begin
                        state_next = S_IDLE;
                    end
                end
                S_CAL: begin
                    if (sif.start_pulse) begin
                        state_next = S_IDLE;
                    end else if (cal_reg == 17'h00000) begin
                        state_next   = S_IDLE;
                        caldone_next = 1'b1;
                    end else begin
                        cal_next = cal_reg - 17'h00001;
                    end
                end
                S_CONV: begin
                    if (tick) begin
                        conv_next = conv_reg - 5'h01;
                    end
                    if (tick && conv_reg == 5'h01) begin
                        // Bipolar core code is offset binary: flip the MSB.
                        result_next = pol_reg
                            ? {~i_raw_code[13], i_raw_code[12:0]}
                            : i_raw_code;
                        sh_next    = result_next;
                        state_next = pend_reg ? S_SW_PDN : S_IDLE;
                    end
                end
                S_IDLE: begin
                    if (sif.byte_pulse) begin
                        gpo_next     = sif.byte_data[CB_GPO_MSB:0];
                        clk_int_next = sif.byte_data[CB_CLK_INT];
                        pend_next    = (mode == MODE_POWER_DOWN_PIN_N);
                        case (mode)
                            MODE_CAL: begin
                                state_next   = S_CAL;
                                cal_next     = 17'(CAL_LEN - 1);
                                caldone_next = 1'b0;
                            end
                            MODE_SHORT: begin
                                long_next  = 1'b0;
                                conv_next  = CONV_SHORT;
                                state_next = S_CONV;
                            end
                            MODE_LONG: begin
                                long_next  = 1'b1;
                                conv_next  = CONV_LONG;
                                state_next = S_CONV;
                            end
                            default: begin
                                conv_next  = long_reg ? CONV_LONG
                                                      : CONV_SHORT;
                                state_next = S_CONV;
                            end
                        endcase
                    end
                end
                default: begin
                    state_next = S_IDLE;
                end
            endcase
        end
        // Range follows the second bit at once, ahead of the mode decode.
        if (sif.pol_pulse && state_next != S_PIN_PDN) begin
            pol_next = sif.pol_bit;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            state_reg   <= S_IDLE;
            conv_reg    <= 5'h00;
            cal_reg     <= 17'h00000;
            div_reg     <= DIV_RESET;
            clk_int_reg <= 1'b0;
            long_reg    <= 1'b0;
            pol_reg     <= 1'b0;
            pend_reg    <= 1'b0;
            caldone_reg <= 1'b0;
            gpo_reg     <= 3'h0;
            result_reg  <= 14'h0000;
            sh_reg      <= 14'h0000;
        end else begin
            state_reg   <= state_next;
            conv_reg    <= conv_next;
            cal_reg     <= cal_next;
            div_reg     <= div_next;
            clk_int_reg <= clk_int_next;
            long_reg    <= long_next;
            pol_reg     <= pol_next;
            pend_reg    <= pend_next;
            // Power-down leaves the calibration flag untouched.
            caldone_reg <= caldone_next;
            gpo_reg     <= gpo_next;
            result_reg  <= result_next;
            sh_reg      <= sh_next;
        end
    end

    // ------------------------------------------------------------------
    // Avalon-MM slave, one wait state on every access
    // ------------------------------------------------------------------
    always_comb begin
        ack_next   = req && !ack_reg;
        cfg_next   = cfg_reg;
        rdata_next = rdata_reg;
        // A write lands only at the edge that sees waitrequest low.
        if (i_avs_write && ack_reg && i_avs_address == REG_CONFIG) begin
            cfg_next = i_avs_writedata[7:0];
        end
        if (req && !ack_reg) begin
            rdata_next = 32'h00000000;
            case (i_avs_address)
                REG_STATUS: begin
                    rdata_next[ST_PDN]        = o_powered_down;
                    rdata_next[ST_CONVERTING] = (state_reg == S_CONV);
                    rdata_next[ST_CALIB]      = (state_reg == S_CAL);
                    rdata_next[ST_BIPOLAR]    = pol_reg;
                    rdata_next[ST_ACQ_LONG]   = long_reg;
                    rdata_next[ST_PIN_PDN]    = (state_reg == S_PIN_PDN);
                    rdata_next[ST_CAL_DONE]   = caldone_reg;
                end
                REG_RESULT: rdata_next[13:0] = result_reg;
                REG_CONFIG: rdata_next[7:0]  = cfg_reg;
                default:    rdata_next       = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            ack_reg   <= 1'b0;
            cfg_reg   <= DIV_RESET;
            rdata_reg <= 32'h00000000;
        end else begin
            ack_reg   <= ack_next;
            cfg_reg   <= cfg_next;
            rdata_reg <= rdata_next;
        end
    end

    assign o_avs_waitrequest       = req && !ack_reg;
    assign o_avs_readdata          = rdata_reg;
    assign o_dout                  = sh_reg[13];
    assign o_gpo                   = gpo_reg;
    assign o_busy                  = (state_reg == S_CONV)
                                   || (state_reg == S_CAL);
    assign o_powered_down          = (state_reg == S_SW_PDN)
                                   || (state_reg == S_PIN_PDN);
    assign o_input_polarity_select = pol_reg;
endmodule

// [verif/adc_shutdown_ctl_monitor.sv]
// Port-level checks on the converter control core.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
module adc_shutdown_ctl_monitor (
    input wire logic        i_clk_sys,
    input wire logic        i_rstn,
    input wire logic        i_sclk,
    input wire logic        i_din,
    input wire logic        i_cs_n,
    input wire logic        i_power_down_pin_n,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    input wire logic [2:0]  o_gpo,
    input wire logic        o_busy,
    input wire logic        o_powered_down
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);
    // ------------------------------------------------------------------
    // Power-down and bus checks
    // ------------------------------------------------------------------
    a_pin_powers_down: assert property (
        !i_power_down_pin_n |-> ##[1:2] o_powered_down)
        else $error("pin low left core awake");
    a_pin_stops_busy: assert property (
        !i_power_down_pin_n |-> ##[1:2] !o_busy)
        else $error("pin low left core busy");
    a_down_not_busy: assert property (
        o_powered_down |-> !o_busy)
        else $error("busy while powered down");
    // Software power-down may only follow the end of a conversion.
    a_down_after_conv: assert property (
        $rose(o_powered_down) && i_power_down_pin_n
        && $past(i_power_down_pin_n) |-> $past(o_busy) || $past(o_busy, 2))
        else $error("power-down without finished conversion");
    a_down_stays: assert property (
        (!i_din)[*4] ##0 (o_powered_down && i_power_down_pin_n)[*2]
        |=> o_powered_down)
        else $error("left power-down without start bit");
    a_start_wakes: assert property (
        o_powered_down && i_power_down_pin_n && $rose(i_sclk) && i_din
        && !i_cs_n |-> ##[1:6] !o_powered_down)
        else $error("start bit did not wake core");
    a_gpo_hold: assert property (
        o_powered_down |=> $stable(o_gpo))
        else $error("logic outputs moved in power-down");
    a_one_wait: assert property (
        (i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest)
        else $error("bus answer not after one wait state");
    a_rdata_hold: assert property (
        !i_avs_read && !i_avs_write |=> $stable(o_avs_readdata))
        else $error("read data moved while idle");
    c_sw_down: cover property ($rose(o_powered_down) && i_power_down_pin_n);
    c_wake: cover property ($fell(o_powered_down) && i_power_down_pin_n);
    c_pin_down: cover property (!i_power_down_pin_n && o_powered_down);
endmodule

bind adc_shutdown_ctl adc_shutdown_ctl_monitor adc_shutdown_ctl_monitor_i (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_sclk(i_sclk),
    .i_din(i_din), .i_cs_n(i_cs_n),
    .i_power_down_pin_n(i_power_down_pin_n), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_gpo(o_gpo),
    .o_busy(o_busy), .o_powered_down(o_powered_down));

// [verif/ser_host_model.sv]
// Serial host model: frames control bytes and clocks conversions.
// Assumes the device samples din on sclk rising edges, MSB first.
`timescale 1ns/10ps
module ser_host_model #(
    parameter int HALF = 4
)(
    input  wire logic i_clk_sys,
    output logic      o_sclk,
    output logic      o_din,
    output logic      o_cs_n
);
    initial begin
        o_sclk = 1'b0;
        o_din  = 1'b1;
        o_cs_n = 1'b1;
    end
    // ------------------------------------------------------------------
    // Frame tasks
    // ------------------------------------------------------------------
    task automatic pulse(input logic d);
        o_din  <= d;
        o_sclk <= 1'b0;
        repeat (HALF) @(posedge i_clk_sys);
        o_sclk <= 1'b1;
        repeat (HALF) @(posedge i_clk_sys);
    endtask
    // The caller forms start, range, clock and mode bits in one byte.
    task automatic start(input logic [7:0] b);
        o_cs_n <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            pulse(b[i]);
        end
    endtask
    task automatic clocks(input int n);
        repeat (n) pulse(1'b0);
    endtask
    // A deselected din is not trusted, so it shows the inverse of its
    // last level rather than a stale bit that could pass for real.
    task automatic stop;
        o_sclk <= 1'b0;
        repeat (HALF) @(posedge i_clk_sys);
        o_cs_n <= 1'b1;
        o_din  <= ~o_din;
        @(posedge i_clk_sys);
    endtask
endmodule

// [verif/tb_adc_shutdown_and_output_coding.sv]
// Self-checking bench for the converter control core.
// Assumes the serial host model and the bound port monitor.
`timescale 1ns/10ps
module tb_adc_shutdown_and_output_coding;
    import adc_ctl_pkg::*;
    logic        clk, rstn, pin_n, rd, wr, wreq, dout, busy, pd, pol;
    logic [13:0] raw;
    logic [3:0]  adr;
    logic [31:0] wd, rdata, q;
    logic [2:0]  gpo;
    logic [5:0]  obs;
    logic        sclk, din, cs_n;
    int          mismatches, num_checks;
    assign obs = {pol, pd, busy, gpo};
    adc_shutdown_ctl #(.CAL_LEN(40)) adc_shutdown_ctl_i (
        .i_clk_sys(clk), .i_rstn(rstn), .i_sclk(sclk), .i_din(din),
        .i_cs_n(cs_n), .i_power_down_pin_n(pin_n), .i_raw_code(raw),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wreq), .o_dout(dout), .o_gpo(gpo),
        .o_busy(busy), .o_powered_down(pd), .o_input_polarity_select(pol));
    ser_host_model host_i (.i_clk_sys(clk), .o_sclk(sclk), .o_din(din),
        .o_cs_n(cs_n));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic av(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        // Waitrequest and read data are taken at the rising edge only.
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 40);
        q = rdata;
        chk({31'h0, wreq}, 32'h0);
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        av(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic sbit(input int b, input logic e);
        av(1'b0, REG_STATUS, 32'h0);
        chk({31'h0, q[b]}, {31'h0, e});
    endtask
    task automatic ochk(input logic [5:0] m, input logic [5:0] e);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({26'h0, obs & m}, {26'h0, e});
        @(posedge clk);
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (busy !== 1'b0 && n < 400);
        chk({31'h0, busy}, 32'h0);
        @(posedge clk);
    endtask
    task automatic end_sim;
        if (mismatches == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        end_sim;
    end
    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        pin_n = 1'b1;
        raw = 14'h2abc;
        rd = 1'b0;
        wr = 1'b0;
        adr = 4'h0;
        wd = 32'h0;
        mismatches = 0;
        num_checks = 0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rchk(REG_CONFIG, {24'h0, DIV_RESET});
        av(1'b1, REG_CONFIG, 32'h0000_0055);
        rchk(REG_CONFIG, 32'h0000_0055);
        av(1'b1, REG_STATUS, 32'hffff_ffff);
        rchk(REG_STATUS, 32'h0);
        rchk(4'hc, 32'h0);
        av(1'b1, 4'hb, 32'h0000_00aa);
        rchk(REG_CONFIG, 32'h0000_0055);
        rchk(4'h9, 32'h0);
        for (int p = 0; p < 2; p++) begin
            raw <= p[0] ? 14'h1543 : 14'h2abc;
            host_i.start({1'b1, p[0], 6'h05});
            ochk(6'h20, {p[0], 5'h0});
            host_i.clocks(15);
            ochk(6'h08, 6'h08);
            host_i.clocks(1);
            chk({31'h0, dout}, {31'h0, raw[13] ^ p[0]});
            host_i.stop;
            ochk(6'h0f, 6'h05);
            rchk(REG_RESULT, {18'h0, raw ^ {p[0], 13'h0}});
        end
        host_i.start(8'h9b);
        host_i.clocks(24);
        host_i.stop;
        sbit(ST_ACQ_LONG, 1'b1);
        host_i.start(8'h92);
        host_i.clocks(16);
        ochk(6'h18, 6'h08);
        host_i.clocks(8);
        host_i.stop;
        ochk(6'h1f, 6'h12);
        sbit(ST_PDN, 1'b1);
        host_i.start(8'h00);
        host_i.clocks(8);
        host_i.stop;
        ochk(6'h1f, 6'h12);
        host_i.start(8'h84);
        ochk(6'h10, 6'h00);
        host_i.clocks(16);
        host_i.stop;
        ochk(6'h1f, 6'h04);
        host_i.start(8'h90);
        host_i.clocks(16);
        host_i.stop;
        ochk(6'h18, 6'h10);
        host_i.start(8'h88);
        host_i.stop;
        pin_n <= 1'b0;
        ochk(6'h18, 6'h10);
        sbit(ST_PIN_PDN, 1'b1);
        pin_n <= 1'b1;
        ochk(6'h18, 6'h00);
        sbit(ST_CAL_DONE, 1'b0);
        host_i.start(8'h88);
        host_i.stop;
        host_i.start(8'h80);
        sbit(ST_CALIB, 1'b0);
        host_i.clocks(16);
        host_i.stop;
        sbit(ST_CAL_DONE, 1'b0);
        host_i.start(8'h88);
        host_i.stop;
        wait_idle;
        sbit(ST_CAL_DONE, 1'b1);
        host_i.start(8'h80);
        host_i.clocks(4);
        pin_n <= 1'b0;
        ochk(6'h18, 6'h10);
        pin_n <= 1'b1;
        host_i.stop;
        sbit(ST_CAL_DONE, 1'b1);
        // Internal conversion clock: 16 ticks of CONFIG+1 system clocks.
        av(1'b1, REG_CONFIG, 32'h0000_0003);
        host_i.start(8'ha1);
        host_i.stop;
        ochk(6'h0f, 6'h09);
        wait_idle;
        chk({31'h0, dout}, {31'h0, raw[13]});
        rchk(REG_RESULT, {18'h0, raw});
        // A reset in mid-run must abort a running calibration.
        host_i.start(8'h88);
        host_i.stop;
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        ochk(6'h3f, 6'h00);
        rchk(REG_CONFIG, {24'h0, DIV_RESET});
        sbit(ST_CALIB, 1'b0);
        end_sim;
    end
endmodule
